// >>> rtl/ps_cfg_device.sv
// device end: status, load-complete, bit capture and initialization
`timescale 1ns/1ps
module ps_cfg_device #(
    parameter int unsigned STATUS_MIN_CYC = ps_cfg_pkg::STATUS_MIN_CYC,
    parameter int unsigned INIT_OSC_CYC   = ps_cfg_pkg::INIT_OSC_CYC,
    parameter int unsigned INIT_USER_CYC  = ps_cfg_pkg::INIT_USER_EDGES,
    parameter int unsigned IMAGE_BITS     = ps_cfg_pkg::IMAGE_BITS_DEF,
    parameter int unsigned OPT_BIT_IDX    = ps_cfg_pkg::OPT_BIT_DEF
) (
    ps_cfg_if.device         link,
    input  wire logic        mclk_in,
    input  wire logic        rst_n_in,
    input  wire logic [1:0]  init_src_in,
    input  wire logic        user_init_clock_in,
    output logic             user_mode_out,
    output logic             init_opt_out
);
    localparam int unsigned BW = $clog2(IMAGE_BITS) + 1;
    localparam int unsigned CW = ps_cfg_pkg::CNT_W;

    ps_cfg_pkg::dev_state_t state_q, state_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic          status_oe_q, status_oe_d;
    logic          done_oe_q, done_oe_d;
    logic          initd_oe_q, initd_oe_d;
    logic          accept_q, accept_d;
    logic          user_q, user_d;
    logic          uclk_prev_q;
    logic [5:0]    sync_s;
    logic          req_s, status_s, done_s, fall2_s, opt_s, uclk_s;
    logic          link_rst_n;
    logic [BW-1:0] bits_q, bits_d;
    logic          done_l_q, done_l_d;
    logic          opt_l_q, opt_l_d;
    logic [1:0]    fall_q, fall_d;

    ////////////////////////////////////////////////////////////////////////
    // link domain, on the host's shift clock

    // held in reset while status is held low; with status monitored, host waits 2 us after release
    assign link_rst_n = rst_n_in & accept_q;

    always_comb
    begin
        bits_d   = bits_q;
        done_l_d = done_l_q;
        opt_l_d  = opt_l_q;
        if (!done_l_q)
        begin
            bits_d = bits_q + 1'b1;
            if (bits_q == BW'(OPT_BIT_IDX))
                opt_l_d = link.serial_bit;
            if (bits_q == BW'(IMAGE_BITS - 1))
                done_l_d = 1'b1;
        end
    end

    always_ff @(posedge link.shift_clk or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            bits_q   <= '0;
            done_l_q <= 1'b0;
            opt_l_q  <= 1'b0;
        end
        else
        begin
            bits_q   <= bits_d;
            done_l_q <= done_l_d;
            opt_l_q  <= opt_l_d;
        end
    end

    // counts falling edges once the image is in; saturates at two
    always_comb
    begin
        fall_d = fall_q;
        if (done_l_q && !fall_q[1])
            fall_d = fall_q + 2'h1;
    end

    always_ff @(negedge link.shift_clk or negedge link_rst_n)
    begin
        if (!link_rst_n)
            fall_q <= 2'h0;
        else
            fall_q <= fall_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // crossings into the mclk domain; fall_q[1] is glitch free

    sync_2ff #(
        .W (6)
    ) u_sync (
        .clk_in   (mclk_in),
        .rst_n_in (rst_n_in),
        .d_in     ({link.cfg_req_n, link.status_n, done_l_q,
                    fall_q[1], opt_l_q, user_init_clock_in}),
        .q_out    (sync_s)
    );

    assign req_s    = sync_s[5];
    assign status_s = sync_s[4];
    assign done_s   = sync_s[3];
    assign fall2_s  = sync_s[2];
    assign opt_s    = sync_s[1];
    assign uclk_s   = sync_s[0];

    ////////////////////////////////////////////////////////////////////////
    // configuration sequencer

    always_comb
    begin
        state_d = state_q;
        cnt_d   = cnt_q;
        case (state_q)
            ps_cfg_pkg::DS_CLEAR:
            begin
                if (!(&cnt_q))
                    cnt_d = cnt_q + 1'b1;
                if (req_s)
                    state_d = ps_cfg_pkg::DS_STATUS;
            end
            ps_cfg_pkg::DS_STATUS:
            begin
                cnt_d = cnt_q + 1'b1;
                // min pulse counted from the fall, well under the max
                if (cnt_q >= CW'(STATUS_MIN_CYC - 1))
                    state_d = ps_cfg_pkg::DS_LOAD;
            end
            ps_cfg_pkg::DS_LOAD:
            begin
                // an external low on status stalls the load
                if (done_s && status_s)
                    state_d = ps_cfg_pkg::DS_FALLS;
            end
            ps_cfg_pkg::DS_FALLS:
            begin
                cnt_d = '0;
                if (fall2_s)
                    state_d = ps_cfg_pkg::DS_INIT;
            end
            ps_cfg_pkg::DS_INIT:
            begin
                case (init_src_in)
                    ps_cfg_pkg::INIT_SRC_OSC:
                    begin
                        cnt_d = cnt_q + 1'b1;
                        if (cnt_q == CW'(INIT_OSC_CYC - 1))
                            state_d = ps_cfg_pkg::DS_USER;
                    end
                    ps_cfg_pkg::INIT_SRC_USER:
                    begin
                        if (cnt_q < CW'(ps_cfg_pkg::USR_EN_CYC))
                            cnt_d = cnt_q + 1'b1;
                        else if (uclk_s && !uclk_prev_q)
                            cnt_d = cnt_q + 1'b1;
                        if (cnt_q == CW'(ps_cfg_pkg::USR_EN_CYC
                                         + INIT_USER_CYC))
                            state_d = ps_cfg_pkg::DS_USER;
                    end
                    default:
                        state_d = ps_cfg_pkg::DS_USER;
                endcase
            end
            ps_cfg_pkg::DS_USER:
                cnt_d = '0;
            default:
                state_d = ps_cfg_pkg::DS_CLEAR;
        endcase
        if (!req_s && state_q != ps_cfg_pkg::DS_CLEAR)
        begin
            state_d = ps_cfg_pkg::DS_CLEAR;
            cnt_d   = '0;
        end
    end

    // pin enables follow the next state so they act one edge sooner
    always_comb
    begin
        status_oe_d = (state_d == ps_cfg_pkg::DS_CLEAR)
                   || (state_d == ps_cfg_pkg::DS_STATUS);
        done_oe_d   = status_oe_d
                   || (state_d == ps_cfg_pkg::DS_LOAD);
        accept_d    = !status_oe_d;
        initd_oe_d  = opt_s && accept_d
                   && (state_d != ps_cfg_pkg::DS_USER);
        user_d      = (state_d == ps_cfg_pkg::DS_USER);
    end

    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_q     <= ps_cfg_pkg::DS_STATUS;
            cnt_q       <= '0;
            status_oe_q <= 1'b1;
            done_oe_q   <= 1'b1;
            initd_oe_q  <= 1'b0;
            accept_q    <= 1'b0;
            user_q      <= 1'b0;
            uclk_prev_q <= 1'b0;
        end
        else
        begin
            state_q     <= state_d;
            cnt_q       <= cnt_d;
            status_oe_q <= status_oe_d;
            done_oe_q   <= done_oe_d;
            initd_oe_q  <= initd_oe_d;
            accept_q    <= accept_d;
            user_q      <= user_d;
            uclk_prev_q <= uclk_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // open-drain pins only ever pull low

    assign link.status_out = 1'b0;
    assign link.status_oe  = status_oe_q;
    assign link.done_out   = 1'b0;
    assign link.done_oe    = done_oe_q;
    assign link.initd_out  = 1'b0;
    assign link.initd_oe   = initd_oe_q;
    assign user_mode_out   = user_q;
    assign init_opt_out    = opt_s;

endmodule : ps_cfg_device

// >>> include/ps_cfg_pkg.sv
// constants and types shared by both ends of the serial config port
package ps_cfg_pkg;

    localparam int unsigned CLK_PERIOD_NS     = 25;
    localparam int unsigned T_CFG_MIN_NS      = 2000;
    localparam int unsigned T_ST2CK_MIN_NS    = 2000;
    localparam int unsigned T_STATUS_MIN_US   = 268;
    localparam int unsigned T_STATUS_MAX_US   = 1506;
    localparam int unsigned T_CF2CK_MIN_US    = 1506;
    localparam int unsigned T_INIT_MIN_US     = 175;
    localparam int unsigned T_INIT_MAX_US     = 437;
    localparam int unsigned T_SCLK_MIN_PER_NS = 8;
    localparam int unsigned INIT_USER_EDGES   = 8576;

    localparam int unsigned CFG_MIN_CYC =
        (T_CFG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned ST2CK_CYC =
        (T_ST2CK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STATUS_MIN_CYC =
        (T_STATUS_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CF2CK_CYC =
        (T_CF2CK_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned INIT_OSC_CYC =
        (T_INIT_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned USR_EN_CYC =
        (4 * T_SCLK_MIN_PER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned HALF_CYC_DEF   = 2;
    localparam int unsigned IMAGE_BITS_DEF = 1024;
    localparam int unsigned OPT_BIT_DEF    = 8;
    localparam int unsigned CNT_W          = 16;

    localparam logic [1:0] INIT_SRC_OSC   = 2'h0;
    localparam logic [1:0] INIT_SRC_USER  = 2'h1;
    localparam logic [1:0] INIT_SRC_SHIFT = 2'h2;

    typedef enum logic [5:0] {
        DS_CLEAR  = 6'h01,
        DS_STATUS = 6'h02,
        DS_LOAD   = 6'h04,
        DS_FALLS  = 6'h08,
        DS_INIT   = 6'h10,
        DS_USER   = 6'h20
    } dev_state_t;

    typedef enum logic [7:0] {
        HS_IDLE = 8'h01,
        HS_REQ  = 8'h02,
        HS_WAIT = 8'h04,
        HS_GAP  = 8'h08,
        HS_LO   = 8'h10,
        HS_HI   = 8'h20,
        HS_TAIL = 8'h40,
        HS_DONE = 8'h80
    } host_state_t;

endpackage : ps_cfg_pkg

// >>> include/ps_cfg_if.sv
// pin bundle between config host and device, open-drain pins resolved
`timescale 1ns/1ps
interface ps_cfg_if;
    logic cfg_req_n;
    logic shift_clk;
    logic serial_bit;
    logic status_out;
    logic status_oe;
    logic done_out;
    logic done_oe;
    logic initd_out;
    logic initd_oe;
    logic status_n;
    logic load_done;
    logic init_done_n;

    // pulled up unless someone drives low
    assign status_n    = !(status_oe && !status_out);
    assign load_done   = !(done_oe && !done_out);
    assign init_done_n = !(initd_oe && !initd_out);

    modport device (
        input  cfg_req_n, shift_clk, serial_bit,
        input  status_n, load_done, init_done_n,
        output status_out, status_oe, done_out, done_oe,
        output initd_out, initd_oe
    );
    modport host (
        output cfg_req_n, shift_clk, serial_bit,
        input  status_n, load_done, init_done_n
    );
endinterface : ps_cfg_if

// >>> rtl/sync_2ff.sv
// two-flop level synchroniser, vector wide
`timescale 1ns/1ps
module sync_2ff #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk_in,
    input  wire logic         rst_n_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            meta_q <= '0;
            q_out  <= '0;
        end
        else
        begin
            meta_q <= d_in;
            q_out  <= meta_q;
        end
    end
endmodule : sync_2ff

// >>> rtl/ps_cfg_host.sv
// host end: request pulse, shift clock divider and bit streaming
`timescale 1ns/1ps
module ps_cfg_host #(
    parameter int unsigned HALF_CYC  = ps_cfg_pkg::HALF_CYC_DEF,
    parameter int unsigned CF2CK_CYC = ps_cfg_pkg::CF2CK_CYC
) (
    ps_cfg_if.host    link,
    input  wire logic mclk_in,
    input  wire logic rst_n_in,
    input  wire logic start_in,
    input  wire logic monitor_status_in,
    input  wire logic bit_valid_in,
    input  wire logic bit_in,
    output logic      bit_ready_out,
    output logic      busy_out,
    output logic      done_out,
    output logic      error_out
);
    localparam int unsigned CW = ps_cfg_pkg::CNT_W;

    ps_cfg_pkg::host_state_t state_q, state_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic          req_n_q, req_n_d;
    logic          sclk_q, sclk_d;
    logic          sbit_q, sbit_d;
    logic          have_q, have_d;
    logic          ready_q, ready_d;
    logic          done_q, done_d;
    logic          err_q, err_d;
    logic          falls_q, falls_d;
    logic          busy_q, busy_d;
    logic [1:0]    sync_s;
    logic          status_s, loaded_s, half_end;

    sync_2ff #(
        .W (2)
    ) u_sync (
        .clk_in   (mclk_in),
        .rst_n_in (rst_n_in),
        .d_in     ({link.status_n, link.load_done}),
        .q_out    (sync_s)
    );

    assign status_s = sync_s[1];
    assign loaded_s = sync_s[0];
    // half period of at least 25 ns keeps the clock under its limit
    assign half_end = (cnt_q >= CW'(HALF_CYC - 1));

    ////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        state_d = state_q;
        cnt_d   = cnt_q + 1'b1;
        req_n_d = req_n_q;
        sclk_d  = sclk_q;
        sbit_d  = sbit_q;
        have_d  = have_q;
        ready_d = 1'b0;
        done_d  = done_q;
        err_d   = err_q;
        falls_d = falls_q;
        case (state_q)
            ps_cfg_pkg::HS_IDLE, ps_cfg_pkg::HS_DONE:
            begin
                cnt_d = '0;
                if (start_in)
                begin
                    state_d = ps_cfg_pkg::HS_REQ;
                    req_n_d = 1'b0;
                    done_d  = 1'b0;
                    err_d   = 1'b0;
                end
            end
            ps_cfg_pkg::HS_REQ:
            begin
                if (cnt_q == CW'(ps_cfg_pkg::CFG_MIN_CYC - 1))
                begin
                    state_d = ps_cfg_pkg::HS_WAIT;
                    req_n_d = 1'b1;
                    cnt_d   = '0;
                end
            end
            ps_cfg_pkg::HS_WAIT:
            begin
                if (monitor_status_in && status_s)
                begin
                    state_d = ps_cfg_pkg::HS_GAP;
                    cnt_d   = '0;
                end
                else if (!monitor_status_in
                         && cnt_q >= CW'(CF2CK_CYC - 1))
                begin
                    state_d = ps_cfg_pkg::HS_LO;
                    cnt_d   = '0;
                end
            end
            ps_cfg_pkg::HS_GAP:
            begin
                if (cnt_q == CW'(ps_cfg_pkg::ST2CK_CYC - 1))
                begin
                    state_d = ps_cfg_pkg::HS_LO;
                    cnt_d   = '0;
                end
            end
            ps_cfg_pkg::HS_LO:
            begin
                // clock pauses low while the source runs dry
                if (!have_q && bit_valid_in && !loaded_s)
                begin
                    sbit_d  = bit_in;
                    have_d  = 1'b1;
                    ready_d = 1'b1;
                end
                if (loaded_s)
                begin
                    state_d = ps_cfg_pkg::HS_TAIL;
                    cnt_d   = '0;
                    falls_d = 1'b0;
                end
                else if (!status_s)
                begin
                    state_d = ps_cfg_pkg::HS_IDLE;
                    err_d   = 1'b1;
                end
                else if (half_end && have_q)
                begin
                    state_d = ps_cfg_pkg::HS_HI;
                    sclk_d  = 1'b1;
                    have_d  = 1'b0;
                    cnt_d   = '0;
                end
            end
            ps_cfg_pkg::HS_HI:
            begin
                if (half_end)
                begin
                    state_d = ps_cfg_pkg::HS_LO;
                    sclk_d  = 1'b0;
                    cnt_d   = '0;
                end
            end
            ps_cfg_pkg::HS_TAIL:
            begin
                if (half_end)
                begin
                    cnt_d  = '0;
                    sclk_d = !sclk_q;
                    if (sclk_q)
                    begin
                        falls_d = 1'b1;
                        if (falls_q)
                        begin
                            state_d = ps_cfg_pkg::HS_DONE;
                            done_d  = 1'b1;
                        end
                    end
                end
            end
            default:
                state_d = ps_cfg_pkg::HS_IDLE;
        endcase
        // registered so the output comes straight from a flop
        busy_d = (state_d != ps_cfg_pkg::HS_IDLE)
              && (state_d != ps_cfg_pkg::HS_DONE);
    end

    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_q <= ps_cfg_pkg::HS_IDLE;
            cnt_q   <= '0;
            req_n_q <= 1'b1;
            sclk_q  <= 1'b0;
            sbit_q  <= 1'b0;
            have_q  <= 1'b0;
            ready_q <= 1'b0;
            done_q  <= 1'b0;
            err_q   <= 1'b0;
            falls_q <= 1'b0;
            busy_q  <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            req_n_q <= req_n_d;
            sclk_q  <= sclk_d;
            sbit_q  <= sbit_d;
            have_q  <= have_d;
            ready_q <= ready_d;
            done_q  <= done_d;
            err_q   <= err_d;
            falls_q <= falls_d;
            busy_q  <= busy_d;
        end
    end

    assign link.cfg_req_n  = req_n_q;
    assign link.shift_clk  = sclk_q;
    assign link.serial_bit = sbit_q;
    assign bit_ready_out   = ready_q;
    assign busy_out        = busy_q;
    assign done_out        = done_q;
    assign error_out       = err_q;

endmodule : ps_cfg_host

// >>> verif/ps_cfg_assertions.sv
// pin-level assertions for the serial config link
`timescale 1ns/1ps
module ps_cfg_assertions #(
    parameter int unsigned STATUS_MIN_CYC = 20,
    parameter int unsigned IMAGE_BITS     = 16
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic cfg_req_n,
    input wire logic shift_clk,
    input wire logic serial_bit,
    input wire logic status_n,
    input wire logic load_done,
    input wire logic init_done_n
);
    // 600 ns at 25 ns per cycle
    localparam int T600    = 24;
    localparam int REL_MAX = STATUS_MIN_CYC + 8;
    logic [15:0] req_q, req_d, st_q, st_d, rise_q, rise_d;
    logic        clk_q, clk_d;
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rst_n_in);
    ////////////////////////////////////////////////////////////
    // counters wrap after 16 bits; fine for shortened counts only
    always_comb
    begin
        clk_d  = shift_clk;
        req_d  = cfg_req_n ? 16'h0000 : req_q + 16'h0001;
        st_d   = status_n ? 16'h0000 : st_q + 16'h0001;
        rise_d = rise_q + {15'h0000, shift_clk & ~clk_q};
        if (!cfg_req_n)
            rise_d = 16'h0000;
    end
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            {clk_q, req_q, st_q, rise_q} <= '0;
        else
            {clk_q, req_q, st_q, rise_q} <= {clk_d, req_d, st_d, rise_d};
    end
    // falls are a few divider cycles apart, so 16 is ample
    sequence s_two_falls;
        ##[1:16] $fell(shift_clk) ##[1:16] $fell(shift_clk);
    endsequence
    sequence s_held_low;
        !shift_clk [*8];
    endsequence
    a_req_status:
    assert property ($fell(cfg_req_n) |-> ##[1:T600] !status_n)
        else $error("status not low after request");
    a_req_done:
    assert property ($fell(cfg_req_n) |-> ##[1:T600] !load_done)
        else $error("load complete not low after request");
    a_req_width:
    assert property ($rose(cfg_req_n) |-> 32'(req_q) >= 80)
        else $error("request pulse too short");
    a_status_min:
    assert property ($rose(status_n) |-> 32'(st_q) + 1 >= STATUS_MIN_CYC)
        else $error("status low pulse too short");
    a_status_rel:
    assert property ($rose(cfg_req_n) |-> ##[1:REL_MAX] status_n)
        else $error("status not released after request");
    a_done_count:
    assert property ($rose(load_done) |-> 32'(rise_q) == IMAGE_BITS)
        else $error("load complete at wrong bit count");
    a_two_falls:
    assert property ($rose(load_done) |-> s_two_falls ##1 s_held_low)
        else $error("missing falls or clock not held low");
    a_opt_in_load:
    assert property ($fell(init_done_n) |-> !load_done && status_n)
        else $error("init-complete fell outside the load");
    a_data_stable:
    assert property ($changed(serial_bit) |-> !shift_clk && !$past(shift_clk))
        else $error("data changed while shift clock high");
    a_clk_high:
    assert property ($rose(shift_clk) |-> shift_clk [*2])
        else $error("shift clock high phase too short");
    a_clk_after_st:
    assert property ($rose(shift_clk) |-> status_n && cfg_req_n)
        else $error("shift clock before status release");
endmodule : ps_cfg_assertions

// >>> verif/tb.sv
// self-checking bench: host and device joined over the config pins
`timescale 1ns/1ps
module tb;
    logic        mclk_in  = 1'b0;
    logic        rst_n_in = 1'b0;
    logic        uclk     = 1'b0;
    logic        start    = 1'b0;
    logic        mon      = 1'b0;
    logic        vld      = 1'b0;
    logic        dbit     = 1'b0;
    logic [1:0]  src      = 2'h0;
    logic [15:0] img      = 16'h0000;
    logic        rdy, busy, hdone, herr, umode, opt;
    int          idx = 0;
    int          lim = 16;
    int          cyc = 0;
    int          mismatches = 0;
    int          n_compared = 0;
    ps_cfg_if    link ();
    ps_cfg_host #(.CF2CK_CYC(20)) ps_cfg_host_i (
        .link              (link),
        .mclk_in           (mclk_in),
        .rst_n_in          (rst_n_in),
        .start_in          (start),
        .monitor_status_in (mon),
        .bit_valid_in      (vld),
        .bit_in            (dbit),
        .bit_ready_out     (rdy),
        .busy_out          (busy),
        .done_out          (hdone),
        .error_out         (herr)
    );
    ps_cfg_device #(
        .STATUS_MIN_CYC (20),
        .INIT_OSC_CYC   (10),
        .INIT_USER_CYC  (8),
        .IMAGE_BITS     (16)
    ) ps_cfg_device_i (
        .link               (link),
        .mclk_in            (mclk_in),
        .rst_n_in           (rst_n_in),
        .init_src_in        (src),
        .user_init_clock_in (uclk),
        .user_mode_out      (umode),
        .init_opt_out       (opt)
    );
    // checker defaults match the shortened device counts
    ps_cfg_assertions ps_cfg_assertions_i (
        .mclk_in     (mclk_in),
        .rst_n_in    (rst_n_in),
        .cfg_req_n   (link.cfg_req_n),
        .shift_clk   (link.shift_clk),
        .serial_bit  (link.serial_bit),
        .status_n    (link.status_n),
        .load_done   (link.load_done),
        .init_done_n (link.init_done_n)
    );
    ////////////////////////////////////////////////////////////
    initial forever #12.5 mclk_in = ~mclk_in;
    initial
    begin
        #40;
        forever #62.5 uclk = ~uclk;
    end
    // bit source moves on only once the host has taken a bit
    always @(posedge mclk_in)
    begin
        #1;
        if (rdy === 1'b1)
            idx++;
        vld  = (idx < lim);
        dbit = img[idx % 16];
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            report_and_stop();
        end
    end
    task automatic step();
        @(posedge mclk_in);
        #1;
    endtask : step
    task automatic check(input logic s, input logic e);
        n_compared++;
        if (s !== e)
        begin
            mismatches++;
            $display("[ERR] %0t seen %b expected %b", $time, s, e);
        end
    endtask : check
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic wait_mode(input int n);
        for (int k = 0; k < n && umode !== 1'b1; k++)
            step();
    endtask : wait_mode
    task automatic run_cfg(input logic [1:0] s, input logic m,
                           input logic [15:0] im, input int n);
        src   = s;
        mon   = m;
        img   = im;
        lim   = n;
        idx   = 0;
        start = 1'b1;
        step();
        start = 1'b0;
        for (int k = 0; k < 24 && (link.status_n || link.load_done); k++)
            step();
        check(link.status_n, 1'b0);
        check(link.load_done, 1'b0);
        for (int k = 0; k < 2000 && hdone !== 1'b1; k++)
            step();
        check(herr, 1'b0);
    endtask : run_cfg
    task automatic t_power_up();
        check(link.status_n, 1'b0);
        check(link.load_done, 1'b0);
        check(link.init_done_n, 1'b1);
        repeat (12) step();
        check(link.status_n, 1'b0);
        repeat (20) step();
        check(link.status_n, 1'b1);
        check(link.load_done, 1'b0);
    endtask : t_power_up
    task automatic t_osc_init();
        run_cfg(2'h0, 1'b1, 16'h0100, 16);
        check(hdone, 1'b1);
        check(link.load_done, 1'b1);
        check(umode, 1'b0);
        check(link.init_done_n, 1'b0);
        repeat (5) step();
        check(umode, 1'b0);
        wait_mode(40);
        check(umode, 1'b1);
        check(opt, 1'b1);
        check(link.init_done_n, 1'b1);
    endtask : t_osc_init
    // bit 8 clear between set neighbours exposes a shifted capture
    task automatic t_user_init();
        run_cfg(2'h1, 1'b0, 16'hfeff, 16);
        check(hdone, 1'b1);
        repeat (20) step();
        check(umode, 1'b0);
        wait_mode(80);
        check(umode, 1'b1);
        check(opt, 1'b0);
        check(link.init_done_n, 1'b1);
    endtask : t_user_init
    // code 3 decodes as the shift clock source too
    task automatic t_shift_init(input logic [1:0] s);
        run_cfg(s, 1'b1, 16'h0100, 16);
        check(hdone, 1'b1);
        wait_mode(8);
        check(umode, 1'b1);
        check(opt, 1'b1);
    endtask : t_shift_init
    // one bit short, then a reset in mid-load to recover
    task automatic t_short_image();
        run_cfg(2'h0, 1'b1, 16'h0100, 15);
        check(link.load_done, 1'b0);
        check(hdone, 1'b0);
        check(umode, 1'b0);
        check(busy, 1'b1);
        rst_n_in = 1'b0;
        repeat (3) step();
        rst_n_in = 1'b1;
    endtask : t_short_image
    initial
    begin
        repeat (3) step();
        rst_n_in = 1'b1;
        t_power_up();
        t_osc_init();
        t_user_init();
        t_shift_init(2'h2);
        t_short_image();
        t_power_up();
        t_shift_init(2'h3);
        report_and_stop();
    end
endmodule : tb
